//--- inc/rfsm_map.svh
// Notes on behaviour
// [RL1] Frame storage runs only in linear or segmented 32-bit addressing, never legacy.
// [RL2] Simplified structure writes data into the descriptor right after its length field.
// [RL3] Simplified structure truncates frames longer than the descriptor data size.
// [RL4] Each truncation increments the no-resource statistics counter.
// [RL5] Truncated descriptor kept if bad frames saved, else reused for next frame.
// [RL6] After a truncated frame reception continues without halting the receive unit.
// [RL7] Save-bad plus promiscuous plus simplified stores any programmed length of every frame.
// [RL8] Flexible structure fills descriptor data area first, then the buffer chain.
// [RL9] Never write more bytes into a buffer than its buffer descriptor allows.
// [RL10] Next buffer descriptor is prefetched before the current buffer fills.
// [RL11] Frames accepted while free buffers remain; exhaustion enters no-resources state. Code: mid-frame only if bad frames saved, else descriptor reused.
// [RL12] Software puts the free buffer list head into the first descriptor.
// [RL13] Software sets buffer pointers of later frame descriptors to all ones.
// [RL14] Kept descriptors get next free buffer address written into next descriptor.
// [RL15] A descriptor with last_descriptor_flag set ends the receive frame area.
// [RL16] A descriptor with its suspend bit set suspends the receive unit afterwards.
// [RL17] structure_select zero is simplified with all-ones buffer pointer, one is flexible.
// [RL18] In-progress bit set at setup, cleared together with completion bit.
`ifndef RFSM_MAP_SVH
`define RFSM_MAP_SVH

`define RFSM_REG_CTRL 8'h00
`define RFSM_REG_RFA 8'h04
`define RFSM_REG_RUST 8'h08
`define RFSM_REG_NRCNT 8'h0C
`define RFSM_REG_ISTAT 8'h10
`define RFSM_REG_IMASK 8'h14

`define RFSM_CTRL_START 0
`define RFSM_CTRL_SAVE 1
`define RFSM_CTRL_PROM 2
`define RFSM_CTRL_MODE_LO 4
`define RFSM_CTRL_MODE_HI 5
`define RFSM_MODE_LEGACY 2'h0

`define RFSM_FD_STAT 32'h0000_0000
`define RFSM_FD_LINK 32'h0000_0004
`define RFSM_FD_BDP 32'h0000_0008
`define RFSM_FD_CNT 32'h0000_000C
`define RFSM_FD_DATA 32'h0000_0010
`define RFSM_BD_LINK 32'h0000_0004

`define RFSM_BIT_C 15
`define RFSM_BIT_B 14
`define RFSM_BIT_OK 13
`define RFSM_BIT_NORES 9
`define RFSM_BIT_EL 31
`define RFSM_BIT_SUSP 30
`define RFSM_BIT_SF 19
`define RFSM_SIZE_LO 16
`define RFSM_SIZE_HI 29
`define RFSM_NONE 32'hFFFF_FFFF

`define RFSM_IRQ_DONE 0
`define RFSM_IRQ_NORES 1
`define RFSM_IRQ_SUSP 2
`define RFSM_IRQ_TRUNC 3

`endif

//--- inc/rfsm_pkg.sv
`default_nettype none
package rfsm_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_FD_RD, S_FD_BUSY, S_BD_RD, S_RECV, S_WR, S_BD_FIN,
    S_FD_CNT, S_FD_STAT, S_LINK, S_NORES, S_SUSP
  } rfsm_state_t;
  typedef logic [3:0] rfsm_strb_t;
endpackage
`default_nettype wire

//--- inc/rfsm_mem_if.sv
`default_nettype none
interface rfsm_mem_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  rfsm_pkg::rfsm_strb_t strb;
  logic done;
  logic [31:0] rdata;
  modport ctl (output req, we, addr, wdata, strb, input done, rdata);
  modport eng (input req, we, addr, wdata, strb, output done, rdata);
endinterface
`default_nettype wire

//--- logic/rfsm_mem.sv
`default_nettype none
module rfsm_mem (
  input wire logic aclk,
  input wire logic aresetn,
  rfsm_mem_if.eng e,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output rfsm_pkg::rfsm_strb_t mem_wstrb,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import rfsm_pkg::*;

  logic done_q;
  logic [31:0] rdata_q;

  // Request held with a stable payload until memory acknowledges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      mem_wstrb <= 4'h0;
    end else if (e.req && !mem_req) begin
      mem_req <= 1'b1;
      mem_we <= e.we;
      mem_addr <= e.addr;
      mem_wdata <= e.wdata;
      mem_wstrb <= e.we ? e.strb : 4'h0;
    end else if (mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      done_q <= mem_req && mem_ack;
      if (mem_req && mem_ack) begin
        rdata_q <= mem_rdata;
      end
    end
  end

  assign e.done = done_q;
  assign e.rdata = rdata_q;

  a_req_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request dropped before acknowledge");
endmodule
`default_nettype wire

//--- logic/rfsm_top.sv
`default_nettype none
`include "rfsm_map.svh"
module rfsm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire rfsm_pkg::rfsm_strb_t s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_good,
  input wire logic rx_match,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output rfsm_pkg::rfsm_strb_t mem_wstrb,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import rfsm_pkg::*;

  rfsm_mem_if mif ();

  rfsm_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .e(mif.eng),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_wstrb(mem_wstrb),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  function automatic logic reg_ok(input logic [7:0] a);
    case (a)
      `RFSM_REG_CTRL, `RFSM_REG_RFA, `RFSM_REG_RUST, `RFSM_REG_NRCNT,
      `RFSM_REG_ISTAT, `RFSM_REG_IMASK: reg_ok = 1'b1;
      default: reg_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i+:8] = s[i] ? n[8*i+:8] : o[8*i+:8];
    end
  endfunction

  rfsm_state_t state_q;
  logic busy_q, rx_ready_q, start_q, save_q, prom_q, mode_err_q, irq_q;
  logic [1:0] idx_q, mode_q;
  logic [31:0] fd_addr_q, link_q, rfa_q, wr_addr_q, word_q, nores_cnt_q;
  logic el_q, susp_q, sf_q, in_buf_q, drop_q, lost_q, infr_q, skip_q, good_q, last_q;
  logic [13:0] fd_size_q, reg_cnt_q, cur_size_q, nxt_size_q;
  logic [31:0] cur_ptr_q, cur_addr_q, nxt_ptr_q, nxt_link_q, nxt_addr_q;
  logic cur_ok_q, nxt_ok_q;
  logic [3:0] strb_q, istat_q, imask_q;
  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  logic [13:0] rsize, fd_cnt;
  logic [1:0] lane;
  logic room, acc, skip, bad, reuse, fin_go, wr_fire;
  logic ev_done, ev_nores, ev_susp, ev_trunc;
  logic [31:0] base, next_free, ru_word;
  rfsm_state_t end_st, fin_next;

  assign rsize = in_buf_q ? cur_size_q : fd_size_q;
  assign fd_cnt = in_buf_q ? fd_size_q : reg_cnt_q;
  assign lane = reg_cnt_q[1:0];
  // Bytes past the room are dropped, not written
  assign room = !drop_q && (reg_cnt_q != rsize);
  assign acc = (state_q == S_RECV) && rx_valid && rx_ready_q;
  assign skip = infr_q ? skip_q : !(rx_match || prom_q);
  assign base = in_buf_q ? cur_addr_q : fd_addr_q + `RFSM_FD_DATA;
  assign next_free = !cur_ok_q ? `RFSM_NONE :
                     (in_buf_q && reg_cnt_q != 14'h0000) ? nxt_ptr_q : cur_ptr_q;
  assign bad = !good_q || lost_q;
  assign reuse = skip_q || (bad && !save_q);
  assign end_st = (in_buf_q && reg_cnt_q != 14'h0000) ? S_BD_FIN : S_FD_CNT;
  // [RL11] [RL15] [RL16] Next receive unit state
  assign fin_next = drop_q ? S_NORES : susp_q ? S_SUSP : el_q ? S_NORES : S_FD_RD;
  assign fin_go = mif.done && ((state_q == S_LINK) || (state_q == S_FD_STAT && el_q));

  always_comb begin
    mif.req = !busy_q && (state_q inside {S_FD_RD, S_FD_BUSY, S_BD_RD, S_WR, S_BD_FIN,
                                          S_FD_CNT, S_FD_STAT, S_LINK});
    mif.we = 1'b1;
    mif.strb = 4'h3;
    mif.addr = fd_addr_q;
    mif.wdata = 32'h0000_0000;
    case (state_q)
      S_FD_RD: begin
        mif.we = 1'b0;
        mif.addr = fd_addr_q + {28'h0000000, idx_q, 2'b00};
      end
      // [RL18] In-progress set at setup
      S_FD_BUSY: mif.wdata[`RFSM_BIT_B] = 1'b1;
      S_BD_RD: begin
        mif.we = 1'b0;
        mif.addr = nxt_ptr_q + {28'h0000000, idx_q, 2'b00};
      end
      S_WR: begin
        mif.addr = wr_addr_q;
        mif.wdata = word_q;
        mif.strb = strb_q;
      end
      S_BD_FIN: begin
        mif.addr = cur_ptr_q;
        mif.wdata = {16'h0000, last_q, 1'b1, reg_cnt_q};
      end
      S_FD_CNT: begin
        mif.addr = fd_addr_q + `RFSM_FD_CNT;
        mif.wdata = {16'h0000, 2'b11, fd_cnt};
      end
      // [RL18] Completion set and in-progress cleared in one write
      S_FD_STAT: begin
        mif.wdata[`RFSM_BIT_C] = 1'b1;
        mif.wdata[`RFSM_BIT_OK] = !bad;
        mif.wdata[`RFSM_BIT_NORES] = lost_q;
      end
      // [RL14] [RL17] Free chain handed to the next descriptor
      S_LINK: begin
        mif.addr = link_q + `RFSM_FD_BDP;
        mif.wdata = sf_q ? next_free : `RFSM_NONE;
        mif.strb = 4'hF;
      end
      default: mif.req = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      busy_q <= 1'b0;
      idx_q <= 2'h0;
      rx_ready_q <= 1'b0;
      {fd_addr_q, link_q, wr_addr_q, word_q} <= {4{32'h0000_0000}};
      {cur_ptr_q, cur_addr_q, nxt_ptr_q, nxt_link_q, nxt_addr_q} <= {5{32'h0000_0000}};
      {fd_size_q, reg_cnt_q, cur_size_q, nxt_size_q} <= {4{14'h0000}};
      {el_q, susp_q, sf_q, in_buf_q, drop_q, lost_q} <= 6'h00;
      {infr_q, skip_q, good_q, last_q, cur_ok_q, nxt_ok_q} <= 6'h00;
      strb_q <= 4'h0;
    end else begin
      if (mif.req) begin
        busy_q <= 1'b1;
      end
      if (mif.done) begin
        busy_q <= 1'b0;
        idx_q <= idx_q + 2'h1;
      end
      case (state_q)
        // [RL1] Legacy addressing never starts frame storage
        S_IDLE, S_SUSP, S_NORES: if (start_q && mode_q != `RFSM_MODE_LEGACY) begin
          fd_addr_q <= rfa_q;
          idx_q <= 2'h0;
          state_q <= S_FD_RD;
        end
        S_FD_RD: if (mif.done) begin
          case (idx_q)
            2'h0: begin
              el_q <= mif.rdata[`RFSM_BIT_EL];
              susp_q <= mif.rdata[`RFSM_BIT_SUSP];
              sf_q <= mif.rdata[`RFSM_BIT_SF];
            end
            2'h1: link_q <= mif.rdata;
            2'h2: nxt_ptr_q <= mif.rdata;
            default: begin
              fd_size_q <= mif.rdata[`RFSM_SIZE_HI:`RFSM_SIZE_LO];
              {reg_cnt_q, strb_q, word_q} <= {14'h0000, 4'h0, 32'h0000_0000};
              {in_buf_q, drop_q, lost_q, infr_q, skip_q, cur_ok_q, nxt_ok_q} <= 7'h00;
              state_q <= S_FD_BUSY;
            end
          endcase
        end
        S_FD_BUSY: if (mif.done) begin
          if (!sf_q) begin
            state_q <= S_RECV;
            rx_ready_q <= 1'b1;
          // [RL11] [RL12] [RL13] Empty free list means no resources
          end else if (nxt_ptr_q == `RFSM_NONE) begin
            state_q <= S_NORES;
          end else begin
            idx_q <= 2'h1;
            state_q <= S_BD_RD;
          end
        end
        S_BD_RD: if (mif.done) begin
          case (idx_q)
            2'h1: nxt_link_q <= mif.rdata;
            2'h2: nxt_addr_q <= mif.rdata;
            default: begin
              idx_q <= 2'h1;
              if (!cur_ok_q) begin
                cur_ptr_q <= nxt_ptr_q;
                cur_addr_q <= nxt_addr_q;
                cur_size_q <= mif.rdata[13:0];
                cur_ok_q <= 1'b1;
                nxt_ptr_q <= nxt_link_q;
              end else begin
                nxt_size_q <= mif.rdata[13:0];
                nxt_ok_q <= 1'b1;
              end
              // [RL10] Fetch the following descriptor before any byte lands
              if (!cur_ok_q && nxt_link_q != `RFSM_NONE) begin
                state_q <= S_BD_RD;
              end else begin
                state_q <= S_RECV;
                rx_ready_q <= 1'b1;
                in_buf_q <= in_buf_q || (fd_size_q == 14'h0000);
              end
            end
          endcase
        end
        S_RECV: if (acc) begin
          infr_q <= !rx_last;
          skip_q <= skip;
          if (rx_last) begin
            good_q <= rx_good;
          end
          // [RL3] [RL7] Excess bytes are cut, filtering off in promiscuous mode
          if (skip || !room) begin
            lost_q <= lost_q || !skip;
            if (rx_last) begin
              last_q <= 1'b1;
              rx_ready_q <= 1'b0;
              state_q <= skip ? S_FD_CNT : end_st;
            end
          // [RL2] [RL8] Descriptor area first, then the current buffer
          end else begin
            word_q[8*lane+:8] <= rx_data;
            strb_q[lane] <= 1'b1;
            reg_cnt_q <= reg_cnt_q + 14'h0001;
            if (lane == 2'h3 || reg_cnt_q + 14'h0001 == rsize || rx_last) begin
              wr_addr_q <= base + {18'h00000, reg_cnt_q[13:2], 2'b00};
              last_q <= rx_last;
              rx_ready_q <= 1'b0;
              state_q <= S_WR;
            end
          end
        end
        S_WR: if (mif.done) begin
          word_q <= 32'h0000_0000;
          strb_q <= 4'h0;
          if (reg_cnt_q == rsize && !in_buf_q && sf_q) begin
            if (cur_ok_q) begin
              in_buf_q <= 1'b1;
              reg_cnt_q <= 14'h0000;
            end else begin
              drop_q <= 1'b1;
            end
          end
          // [RL9] A full buffer is closed at exactly its size
          if (reg_cnt_q == rsize && in_buf_q) begin
            state_q <= S_BD_FIN;
          end else if (last_q) begin
            state_q <= end_st;
          end else begin
            state_q <= S_RECV;
            rx_ready_q <= 1'b1;
          end
        end
        S_BD_FIN: if (mif.done) begin
          if (last_q) begin
            state_q <= S_FD_CNT;
          end else begin
            reg_cnt_q <= 14'h0000;
            nxt_ok_q <= 1'b0;
            cur_ok_q <= nxt_ok_q;
            drop_q <= !nxt_ok_q;
            {cur_ptr_q, cur_addr_q, cur_size_q} <= {nxt_ptr_q, nxt_addr_q, nxt_size_q};
            nxt_ptr_q <= nxt_ok_q ? nxt_link_q : `RFSM_NONE;
            idx_q <= 2'h1;
            // [RL10] Prefetch again as soon as a buffer is taken
            if (nxt_ok_q && nxt_link_q != `RFSM_NONE) begin
              state_q <= S_BD_RD;
            end else begin
              state_q <= S_RECV;
              rx_ready_q <= 1'b1;
            end
          end
        end
        // [RL5] [RL6] Dropped or unsaved bad frame reuses the descriptor
        S_FD_CNT: if (mif.done) begin
          idx_q <= 2'h0;
          state_q <= reuse ? S_FD_RD : S_FD_STAT;
        end
        S_FD_STAT: if (mif.done) begin
          state_q <= el_q ? fin_next : S_LINK;
        end
        S_LINK: if (mif.done) begin
          state_q <= fin_next;
          fd_addr_q <= link_q;
          idx_q <= 2'h0;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign ev_done = (state_q == S_FD_STAT) && mif.done;
  assign ev_trunc = (state_q == S_FD_CNT) && mif.done && lost_q && !skip_q;
  assign ev_susp = fin_go && fin_next == S_SUSP;
  assign ev_nores = (fin_go && fin_next == S_NORES) ||
                    (state_q == S_FD_BUSY && mif.done && sf_q && nxt_ptr_q == `RFSM_NONE);
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  // [RL4] No-resource statistics on every truncation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nores_cnt_q <= 32'h0000_0000;
    end else if (ev_trunc) begin
      nores_cnt_q <= nores_cnt_q + 32'h0000_0001;
    end
  end

  // Status bits: a new event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {start_q, save_q, prom_q, mode_err_q, irq_q} <= 5'h00;
      mode_q <= 2'h0;
      {rfa_q} <= 32'h0000_0000;
      {istat_q, imask_q} <= 8'h00;
    end else begin
      start_q <= wr_fire && awaddr_q == `RFSM_REG_CTRL && wstrb_q[0] &&
                 wdata_q[`RFSM_CTRL_START];
      if (start_q) begin
        mode_err_q <= mode_q == `RFSM_MODE_LEGACY;
      end
      if (wr_fire && awaddr_q == `RFSM_REG_CTRL && wstrb_q[0]) begin
        save_q <= wdata_q[`RFSM_CTRL_SAVE];
        prom_q <= wdata_q[`RFSM_CTRL_PROM];
        mode_q <= wdata_q[`RFSM_CTRL_MODE_HI:`RFSM_CTRL_MODE_LO];
      end
      if (wr_fire && awaddr_q == `RFSM_REG_RFA) begin
        rfa_q <= merge(rfa_q, wdata_q, wstrb_q);
      end
      if (wr_fire && awaddr_q == `RFSM_REG_IMASK && wstrb_q[0]) begin
        imask_q <= wdata_q[3:0];
      end
      istat_q <= (istat_q & ~((wr_fire && awaddr_q == `RFSM_REG_ISTAT && wstrb_q[0]) ?
                 wdata_q[3:0] : 4'h0)) | {ev_trunc, ev_susp, ev_nores, ev_done};
      irq_q <= |(istat_q & imask_q);
    end
  end

  always_comb begin
    ru_word = {27'h0000000, mode_err_q, 4'h3};
    case (state_q)
      S_IDLE: ru_word[3:0] = 4'h0;
      S_SUSP: ru_word[3:0] = 4'h1;
      S_NORES: ru_word[3:0] = 4'h2;
      default: ru_word[3:0] = 4'h3;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_hold_q, w_hold_q, bvalid_q, rvalid_q} <= 4'h0;
      {awready_q, wready_q, arready_q} <= 3'h7;
      awaddr_q <= 8'h00;
      {wdata_q, rdata_q} <= {2{32'h0000_0000}};
      wstrb_q <= 4'h0;
      {bresp_q, rresp_q} <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && wready_q) begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        {aw_hold_q, w_hold_q} <= 2'b00;
        bvalid_q <= 1'b1;
        bresp_q <= reg_ok(awaddr_q) ? 2'b00 : 2'b10;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        {awready_q, wready_q} <= 2'b11;
      end
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= reg_ok({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b10;
        case ({s_axi_araddr[7:2], 2'b00})
          `RFSM_REG_CTRL: rdata_q <= {26'h0000000, mode_q, 1'b0, prom_q, save_q, 1'b0};
          `RFSM_REG_RFA: rdata_q <= rfa_q;
          `RFSM_REG_RUST: rdata_q <= ru_word;
          `RFSM_REG_NRCNT: rdata_q <= nores_cnt_q;
          `RFSM_REG_ISTAT: rdata_q <= {28'h0000000, istat_q};
          `RFSM_REG_IMASK: rdata_q <= {28'h0000000, imask_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} =
         {awready_q, wready_q, bvalid_q, bresp_q};
  assign {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} =
         {arready_q, rvalid_q, rdata_q, rresp_q};
  assign irq = irq_q;
  assign rx_ready = rx_ready_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_legacy_idle: assert property (state_q == S_IDLE && mode_q == `RFSM_MODE_LEGACY // RL1
    |=> state_q == S_IDLE) else $error("legacy mode started reception");
  a_simple_nobd: assert property (state_q inside {S_BD_RD, S_BD_FIN} |-> sf_q) // RL2
    else $error("buffer descriptor touched in simplified mode");
  a_trunc_count: assert property (ev_trunc // RL4
    |=> nores_cnt_q == $past(nores_cnt_q) + 32'h0000_0001) else $error("counter missed");
  a_reuse_same: assert property (state_q == S_FD_CNT && mif.done && reuse // RL5
    |=> state_q == S_FD_RD && fd_addr_q == $past(fd_addr_q)) else $error("no reuse");
  a_buf_bound: assert property (in_buf_q && cur_ok_q |-> reg_cnt_q <= cur_size_q) // RL9
    else $error("buffer overfilled");
  a_prefetch_ready: assert property (acc && in_buf_q && cur_ok_q // RL10
    && nxt_ptr_q != `RFSM_NONE |-> nxt_ok_q) else $error("next descriptor not prefetched");
  a_nores_entry: assert property (state_q == S_LINK && mif.done && drop_q // RL11
    |=> state_q == S_NORES ##1 state_q == S_NORES) else $error("no-resources not entered");
  a_link_write: assert property (state_q == S_LINK && mif.req // RL14
    |-> mif.addr == link_q + `RFSM_FD_BDP && mif.strb == 4'hF) else $error("bad link write");
  a_last_stop: assert property (state_q == S_FD_STAT && mif.done && el_q // RL15
    && !drop_q && !susp_q |=> state_q == S_NORES) else $error("ran past last descriptor");
  a_suspend_req: assert property (fin_go && !drop_q && susp_q // RL16
    |=> state_q == S_SUSP) else $error("suspend ignored");
  a_done_clears: assert property (state_q == S_FD_STAT && mif.req // RL18
    |-> mif.wdata[`RFSM_BIT_C] && !mif.wdata[`RFSM_BIT_B]) else $error("C and B mismatch");
  c_trunc: cover property (ev_trunc);
  c_buf_switch: cover property (state_q == S_BD_FIN && mif.done && !last_q);
  c_suspend: cover property (ev_susp);
endmodule
`default_nettype wire

//--- verif/rfsm_mem_model.sv
`default_nettype none
module rfsm_mem_model (
  input wire logic aclk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire rfsm_pkg::rfsm_strb_t mem_wstrb,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import rfsm_pkg::*;
  logic [31:0] m [0:255];
  int slow = 0;
  int w = 0;
  initial mem_ack = 1'h0;
  initial mem_rdata = 32'h0;
  always @(posedge aclk) begin
    mem_ack <= 1'h0;
    // Read data is only good with ack, so it toggles in between
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      w <= w + 1;
      if (w >= slow) begin
        w <= 0;
        mem_ack <= 1'h1;
        mem_rdata <= m[mem_addr[9:2]];
        for (int b = 0; b < 4; b++)
          if (mem_we && mem_wstrb[b]) m[mem_addr[9:2]][8*b+:8] <= mem_wdata[8*b+:8];
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/rfsm_top_tb.sv
`default_nettype none
module rfsm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rfsm_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic rx_valid, rx_ready, rx_last, rx_good, rx_match, mem_req, mem_we, mem_ack;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, mem_wdata, mem_rdata, rdq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsq;
  rfsm_strb_t s_axi_wstrb, mem_wstrb;
  logic [7:0] q[$];
  int bad_count = 0;
  int checks = 0;
  int seed = 53;
  rfsm_top u_dut (.*);
  rfsm_mem_model u_mem (.*);
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, released after the next rising edge
  task automatic ax(input bit rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ta, tw, tb;
    n = 0;
    s_axi_araddr <= a;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_arvalid <= rd;
    s_axi_awvalid <= !rd;
    s_axi_wvalid <= !rd;
    do begin
      @(negedge aclk);
      n++;
      ta = rd ? s_axi_arready : s_axi_awready;
      tw = s_axi_wready;
      tb = rd ? s_axi_rvalid : s_axi_bvalid;
      rdq = s_axi_rdata;
      rsq = rd ? s_axi_rresp : s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!tb && n < 50);
    if (!tb) begin bad_count++; test_done; end
  endtask
  task automatic send(input int len);
    int n;
    bit t;
    logic [7:0] b;
    q.delete();
    for (int i = 0; i < len; i++) begin
      b = 8'($random(seed));
      q.push_back(b);
      rx_data <= b;
      rx_valid <= 1'h1;
      rx_last <= i == len - 1;
      n = 0;
      do begin
        @(negedge aclk);
        t = rx_ready;
        n++;
        @(posedge aclk);
      end while (!t && n < 300);
      if (!t) begin bad_count++; test_done; end
    end
    rx_valid <= 1'h0;
    rx_last <= 1'h0;
  endtask
  task automatic waitst(input logic [31:0] m);
    int n;
    n = 0;
    do begin ax(1, 8'h10, 32'h0); n++; end while ((rdq & m) != m && n < 100);
    chk("istat", rdq & m, m);
    chk("irq", irq, 1);
    if ((rdq & m) != m) test_done;
    ax(0, 8'h10, m);
  endtask
  initial begin
    aresetn <= 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rx_valid, rx_last} <= '0;
    {s_axi_bready, s_axi_rready, rx_good, rx_match, s_axi_wstrb} <= '1;
    {s_axi_awaddr, s_axi_araddr, rx_data, s_axi_wdata} <= '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    u_mem.m[64:69] = '{32'h0, 32'h200, '1, 32'h0004_0000, 32'h0, 32'h0};
    u_mem.m[128:131] = '{32'h4000_0000, 32'h100, '1, 32'h0008_0000};
    ax(0, 8'h00, 32'h01);
    ax(1, 8'h08, 32'h0);
    chk("rust", rdq & 32'h1F, 32'h10);
    ax(1, 8'h40, 32'h0);
    chk("rresp", 32'(rsq), 32'h2);
    $display("test legacy done");
    ax(0, 8'h14, 32'hF);
    chk("bresp", 32'(rsq), 32'h0);
    ax(0, 8'h04, 32'h100);
    ax(0, 8'h00, 32'h21);
    send(6);
    waitst(32'h8);
    ax(1, 8'h0C, 32'h0);
    chk("nrcnt", rdq, 1);
    chk("data", u_mem.m[68], {q[3], q[2], q[1], q[0]});
    chk("spill", u_mem.m[69], 0);
    $display("test truncate done");
    u_mem.slow = 2;
    send(3);
    waitst(32'h1);
    chk("data", u_mem.m[68][23:0], {q[2], q[1], q[0]});
    chk("stat", u_mem.m[64][15:13], 3'h5);
    chk("count", u_mem.m[67][13:0], 3);
    chk("bdp", u_mem.m[130], '1);
    $display("test reuse done");
    send(2);
    waitst(32'h5);
    ax(1, 8'h08, 32'h0);
    chk("rust", rdq[3:0], 1);
    chk("data", u_mem.m[132][15:0], {q[1], q[0]});
    $display("test suspend done");
    // flexible descriptor, one buffer filled, a second half filled, a third prefetched
    u_mem.m[64:66] = '{32'h0008_0000, 32'h200, 32'h300};
    u_mem.m[193:195] = '{32'h340, 32'h380, 32'h4};
    u_mem.m[209:211] = '{32'h3D0, 32'h3C0, 32'h4};
    u_mem.m[245:247] = '{'1, 32'h3E0, 32'h4};
    ax(0, 8'h00, 32'h21);
    send(10);
    waitst(32'h1);
    chk("fdata", u_mem.m[68], {q[3], q[2], q[1], q[0]});
    chk("buf1", u_mem.m[224], {q[7], q[6], q[5], q[4]});
    chk("buf2", u_mem.m[240][15:0], {q[9], q[8]});
    chk("bd1", u_mem.m[192][15:0], 16'h4004);
    chk("bd2", u_mem.m[208][15:0], 16'hC002);
    chk("next", u_mem.m[130], 32'h3D0);
    $display("test flexible done");
    ax(0, 8'h00, 32'h26);
    rx_match <= 1'h0;
    send(10);
    waitst(32'hC);
    chk("mon", u_mem.m[133], {q[7], q[6], q[5], q[4]});
    chk("kept", u_mem.m[128][15:0], 16'h8200);
    ax(1, 8'h0C, 32'h0);
    chk("nrcnt", rdq, 2);
    $display("test monitor done");
    test_done;
  end
endmodule
`default_nettype wire
